// [logic/cpu_supervisor_host_port.sv]
// cpu supervisor: processor reset, watchdog, power-fail flag,
// alarm interrupt, sram enable gating and serial command capture
// assumes every pin input is asynchronous to core_clk and that the
// alarm flag and enable come from logic clocked by core_clk
//
// Notes on behaviour
// - the sram enable output goes low only while the enable input is low.
// - the interrupt is active high and stays high while flag and enable hold.
// - the interrupt path does not depend on the supply state.
// - the power-fail flag output is low while the sense input is below threshold.
// - the reset is driven low for bad supply, watchdog, power-up and button.
// - a debounced low on the reset pin yields a reset of at least 250 ms.
// - a watchdog period without a low strobe forces a processor reset.
// - for the power-up delay after the supply comes good the strobe, reset pin, serial and sram enable inputs are ignored.
// - after the supply returns the reset is held for 250 ms before release.
// - each transfer opens with a command byte; its low seven bits are the address.
// - bit 7 of the command byte is zero for read and one for write.
// - the interrupt rises when the alarm flag and its enable are both set.
// - the sram enable output is forced inactive during power transients.

`timescale 1ns/100ps
`include "supervisor_cfg.svh"

module cpu_supervisor_host_port #(
  parameter int unsigned HOLD_CYCLES     =
    supervisor_pkg::msToCycles(`HOLD_MS),
  parameter int unsigned BUTTON_CYCLES   =
    supervisor_pkg::msToCycles(`BUTTON_MS),
  parameter int unsigned DEBOUNCE_CYCLES =
    supervisor_pkg::msToCycles(`DEBOUNCE_MS),
  parameter int unsigned WDOG_CYCLES     =
    supervisor_pkg::msToCycles(`WDOG_MS)
) (
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  input  wire logic             supplyInTol,
  input  wire logic             powerfailSenseIn,
  input  wire logic             ramEnableInN,
  input  wire logic             watchdogKickN,
  input  wire logic             rstPinIn,
  output logic                  rstPinOut,
  output logic                  rstPinOe,
  input  wire logic             csIn,
  input  wire logic             sclkIn,
  input  wire logic             sdiIn,
  input  wire logic             alarmRequestFlag,
  input  wire logic             alarmIrqEnable,
  output logic                  irqOut,
  output logic                  ramEnableOutN,
  output logic                  powerfailFlagOutN,
  output logic                  cmdValid,
  output supervisor_pkg::cmd_type cmdOut
);
  import supervisor_pkg::*;

  pins_type    pinsRaw;
  pins_type    sync1_q;
  pins_type    sync2_q;
  logic        sclkPrev_q;
  logic        kickPrev_q;
  state_type   state_q;
  state_type   state_d;
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic [31:0] dbCnt_q;
  logic [2:0]  bitCnt_q;
  logic        gotCmd_q;
  logic [6:0]  shift_q;
  logic        rstOe_q;
  logic        rstOut_q;
  logic        irq_q;
  logic        ramEnN_q;
  logic        pfFlag_q;
  logic        cmdValid_q;
  cmd_type     cmd_q;

  assign pinsRaw = {supplyInTol, powerfailSenseIn, ramEnableInN,
                    rstPinIn, watchdogKickN, csIn, sclkIn, sdiIn};

  // two-stage synchronisers; only sync2_q is looked at by logic
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sync1_q <= `PINS_RST;
      sync2_q <= `PINS_RST;
    end else begin
      sync1_q <= pinsRaw;
      sync2_q <= sync1_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sclkPrev_q <= 1'b0;
      kickPrev_q <= 1'b1;
    end else begin
      sclkPrev_q <= sync2_q.sclk;
      kickPrev_q <= sync2_q.kickN;
    end
  end

  wire supplyGood = sync2_q.supplyOk;
  wire running    = (state_q == S_RUN);
  wire sclkRise   = sync2_q.cs && sync2_q.sclk && !sclkPrev_q;
  wire kickFall   = running && !sync2_q.kickN && kickPrev_q;
  wire buttonLow  = running && !sync2_q.rstPin;
  wire buttonDone = buttonLow &&
                    (dbCnt_q == 32'(DEBOUNCE_CYCLES - 1));
  wire wdogEnd    = running && (cnt_q == 32'(WDOG_CYCLES - 1));
  wire holdDone   = (cnt_q == 32'(HOLD_CYCLES - 1));
  wire forceDone  = (cnt_q == 32'(BUTTON_CYCLES - 1));
  wire lastBit    = running && sclkRise && !gotCmd_q &&
                    (bitCnt_q == `BIT_LAST);
  // the sram may be enabled only once the supply has settled
  wire ramAllowed = supplyGood && (state_q == S_RUN ||
                                   state_q == S_FORCE);

  // one counter serves the hold, the forced reset and the watchdog,
  // since only one of them can be running at a time
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q + 32'h1;
    if (!supplyGood) begin
      state_d = S_OFF;
      cnt_d   = 32'h0;
    end else begin
      case (state_q)
        S_OFF: begin
          state_d = S_HOLD;
          cnt_d   = 32'h0;
        end
        S_HOLD: begin
          if (holdDone) begin
            state_d = S_RUN;
            cnt_d   = 32'h0;
          end
        end
        S_RUN: begin
          if (buttonDone) begin
            state_d = S_FORCE;
            cnt_d   = 32'h0;
          end else if (kickFall) begin
            cnt_d = 32'h0;
          end else if (wdogEnd) begin
            state_d = S_FORCE;
            cnt_d   = 32'h0;
          end
        end
        S_FORCE: begin
          if (forceDone) begin
            state_d = S_RUN;
            cnt_d   = 32'h0;
          end
        end
        default: begin
          state_d = S_OFF;
          cnt_d   = 32'h0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_q <= S_OFF;
      cnt_q   <= 32'h0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  // debounce: the pin must stay low for the whole window; a bounce
  // restarts it. our own release is too short to fool it.
  always_ff @(posedge core_clk) begin
    if (sys_rst || !buttonLow) begin
      dbCnt_q <= 32'h0;
    end else begin
      dbCnt_q <= dbCnt_q + 32'h1;
    end
  end

  // command byte capture, lsb first on rising serial clock; bytes
  // after the first belong to the data phase and are not taken here
  always_ff @(posedge core_clk) begin
    if (sys_rst || !running || !sync2_q.cs) begin
      bitCnt_q <= 3'h0;
      gotCmd_q <= 1'b0;
      shift_q  <= 7'h00;
    end else if (sclkRise && !gotCmd_q) begin
      shift_q  <= {sync2_q.sdi, shift_q[6:1]};
      bitCnt_q <= bitCnt_q + 3'h1;
      gotCmd_q <= (bitCnt_q == `BIT_LAST);
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cmdValid_q <= 1'b0;
      cmd_q      <= '0;
    end else begin
      cmdValid_q <= lastBit;
      if (lastBit) begin
        cmd_q.write <= sync2_q.sdi;
        cmd_q.addr  <= shift_q;
      end
    end
  end

  // the interrupt is not gated by supply so an alarm can wake
  // a powered-down system
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      irq_q    <= 1'b0;
      ramEnN_q <= 1'b1;
      pfFlag_q <= 1'b1;
      rstOe_q  <= 1'b1;
      rstOut_q <= 1'b0;
    end else begin
      irq_q    <= alarmRequestFlag && alarmIrqEnable;
      ramEnN_q <= sync2_q.ramEnN || !ramAllowed;
      pfFlag_q <= sync2_q.pfSense;
      rstOe_q  <= (state_d != S_RUN);
      rstOut_q <= 1'b0;
    end
  end

  assign rstPinOut         = rstOut_q;
  assign rstPinOe          = rstOe_q;
  assign irqOut            = irq_q;
  assign ramEnableOutN     = ramEnN_q;
  assign powerfailFlagOutN = pfFlag_q;
  assign cmdValid          = cmdValid_q;
  assign cmdOut            = cmd_q;

  // helper: length of the current reset drive, saturating
  logic [31:0] lowLen_q;
  always_ff @(posedge core_clk) begin
    if (sys_rst || !rstOe_q) begin
      lowLen_q <= 32'h0;
    end else if (lowLen_q != 32'hffffffff) begin
      lowLen_q <= lowLen_q + 32'h1;
    end
  end

  localparam int unsigned MIN_LOW =
    (HOLD_CYCLES < BUTTON_CYCLES) ? HOLD_CYCLES : BUTTON_CYCLES;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_lastBit;
    supplyGood && lastBit;
  endsequence

  sequence s_wdogEnd;
    supplyGood && wdogEnd && !kickFall && !buttonDone;
  endsequence

  property p_pfFollow;
    !$past(sys_rst, 4) && $stable(powerfailSenseIn) [*4]
      |-> powerfailFlagOutN == powerfailSenseIn;
  endproperty
  a_pfFollow: assert property (p_pfFollow)
    else $error("power-fail flag does not follow sense input");

  property p_irqSet;
    alarmRequestFlag && alarmIrqEnable |=> irqOut;
  endproperty
  a_irqSet: assert property (p_irqSet)
    else $error("interrupt not raised for flag and enable");
  property p_irqClear;
    !(alarmRequestFlag && alarmIrqEnable) |=> !irqOut;
  endproperty
  a_irqClear: assert property (p_irqClear)
    else $error("interrupt high without flag and enable");
  property p_ramGate;
    !supplyGood |=> ramEnableOutN [*2];
  endproperty
  a_ramGate: assert property (p_ramGate)
    else $error("sram enabled during power transient");
  property p_ramPass;
    ramAllowed && !sync2_q.ramEnN |=> !ramEnableOutN;
  endproperty
  a_ramPass: assert property (p_ramPass)
    else $error("sram enable not passed through");
  property p_supplyReset;
    !supplyGood |=> rstPinOe && !rstPinOut && state_q == S_OFF;
  endproperty
  a_supplyReset: assert property (p_supplyReset)
    else $error("reset not driven for bad supply");
  property p_resetLen;
    $fell(rstPinOe) |-> $past(lowLen_q) >= 32'(MIN_LOW - 1);
  endproperty
  a_resetLen: assert property (p_resetLen)
    else $error("processor reset released too early");
  property p_watchdog;
    s_wdogEnd |=> state_q == S_FORCE && rstPinOe;
  endproperty
  a_watchdog: assert property (p_watchdog)
    else $error("watchdog expiry did not force reset");

  property p_kick;
    supplyGood && kickFall && !buttonDone |=> cnt_q == 32'h0 && running;
  endproperty
  a_kick: assert property (p_kick)
    else $error("strobe did not restart watchdog period");

  property p_csLow;
    !sync2_q.cs |=> !cmdValid && bitCnt_q == 3'h0;
  endproperty
  a_csLow: assert property (p_csLow)
    else $error("serial activity taken with select low");

  property p_ignoreHold;
    !running |=> !cmdValid && dbCnt_q == 32'h0;
  endproperty
  a_ignoreHold: assert property (p_ignoreHold)
    else $error("input taken outside run state");

  property p_command;
    s_lastBit |=> cmdValid && cmdOut.write == $past(sync2_q.sdi)
                 && cmdOut.addr == $past(shift_q);
  endproperty
  a_command: assert property (p_command)
    else $error("command byte captured wrongly");

  property p_buttonReset;
    supplyGood && buttonDone |=> state_q == S_FORCE ##1 rstPinOe;
  endproperty
  a_buttonReset: assert property (p_buttonReset)
    else $error("debounced button did not force reset");

endmodule : cpu_supervisor_host_port

// [logic/supervisor_cfg.svh]
// constants for the cpu supervisor: clock rate, times, reset values
// assumes the includer wants plain text macros, no types
`ifndef SUPERVISOR_CFG_SVH
`define SUPERVISOR_CFG_SVH

`define CLK_HZ        50000000
`define HOLD_MS       250
`define BUTTON_MS     250
`define DEBOUNCE_MS   10
`define WDOG_MS       1000
`define PINS_RST      8'h78
`define BIT_LAST      3'h7

`endif

// [logic/supervisor_pkg.sv]
// types shared by the cpu supervisor
// assumes supervisor_cfg.svh is present in the include path
`include "supervisor_cfg.svh"

package supervisor_pkg;

  typedef enum logic [1:0] {
    S_OFF,
    S_HOLD,
    S_RUN,
    S_FORCE
  } state_type;

  // raw pins, all from outside the core clock
  typedef struct packed {
    logic supplyOk;
    logic pfSense;
    logic ramEnN;
    logic rstPin;
    logic kickN;
    logic cs;
    logic sclk;
    logic sdi;
  } pins_type;

  typedef struct packed {
    logic       write;
    logic [6:0] addr;
  } cmd_type;

  function automatic int unsigned msToCycles(input int unsigned ms);
    return (`CLK_HZ / 1000) * ms;
  endfunction : msToCycles

endpackage : supervisor_pkg

// [sim/host_model.sv]
// host side model: serial command sender and watchdog kicker
// assumes core_clk from the bench; the link clock idles low between
// frames and every change is made at a core clock edge
`timescale 1ns/100ps
module host_model (
  input  wire logic core_clk,
  output logic      csIn,
  output logic      sclkIn,
  output logic      sdiIn,
  output logic      watchdogKickN
);
  initial begin
    csIn = 1'b0;
    sclkIn = 1'b0;
    sdiIn = 1'b1;
    watchdogKickN = 1'b1;
  end
  // link clock of 8 core cycles, lsb first; select spans the whole frame
  task automatic sendBits(input logic [7:0] cmd, input int nBits);
    csIn <= 1'b1;
    for (int i = 0; i < nBits; i++) begin
      sdiIn <= cmd[i];
      repeat (4) @(posedge core_clk);
      sclkIn <= 1'b1;
      repeat (4) @(posedge core_clk);
      sclkIn <= 1'b0;
    end
    repeat (4) @(posedge core_clk);
    csIn <= 1'b0;
    // released data line flips so a stale bit is never read as valid
    sdiIn <= ~sdiIn;
    repeat (4) @(posedge core_clk);
  endtask : sendBits
  // low for four cycles: shorter strobes may slip past the synchroniser
  task automatic kick();
    watchdogKickN <= 1'b0;
    repeat (4) @(posedge core_clk);
    watchdogKickN <= 1'b1;
    @(posedge core_clk);
  endtask : kick
endmodule : host_model

// [sim/cpu_supervisor_host_port_test.sv]
// self-checking bench for the cpu supervisor host port
// assumes host_model drives select, link clock, data and kick strobe
`timescale 1ns/100ps
module cpu_supervisor_host_port_test;
  import supervisor_pkg::*;
  localparam int unsigned HOLD = 20;
  localparam int unsigned BTN  = 20;
  localparam int unsigned DEB  = 5;
  localparam int unsigned WDOG = 200;
  logic       core_clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       supplyInTol = 1'b0;
  logic       powerfailSenseIn = 1'b1;
  logic       ramEnableInN = 1'b1;
  logic       buttonN = 1'b1;
  logic       alarmRequestFlag = 1'b0;
  logic       alarmIrqEnable = 1'b0;
  logic       rstPinOut, rstPinOe, irqOut, ramEnableOutN;
  logic       powerfailFlagOutN, cmdValid;
  logic       csIn, sclkIn, sdiIn, watchdogKickN;
  wire        rstPinIn;
  cmd_type    cmdOut;
  logic [7:0] lastCmd;
  int         cmdCount = 0;
  int         errors = 0;
  int         tests_run = 0;
  int         n;
  // open-drain pin with pull-up: low if the button or the block pulls
  assign rstPinIn = buttonN & ~(rstPinOe & ~rstPinOut);
  initial begin
    forever #10 core_clk = ~core_clk;
  end
  cpu_supervisor_host_port #(
    .HOLD_CYCLES(HOLD), .BUTTON_CYCLES(BTN),
    .DEBOUNCE_CYCLES(DEB), .WDOG_CYCLES(WDOG)
  ) i_cpu_supervisor_host_port (
    .core_clk(core_clk), .sys_rst(sys_rst), .supplyInTol(supplyInTol),
    .powerfailSenseIn(powerfailSenseIn), .ramEnableInN(ramEnableInN),
    .watchdogKickN(watchdogKickN), .rstPinIn(rstPinIn),
    .rstPinOut(rstPinOut), .rstPinOe(rstPinOe), .csIn(csIn),
    .sclkIn(sclkIn), .sdiIn(sdiIn), .alarmRequestFlag(alarmRequestFlag),
    .alarmIrqEnable(alarmIrqEnable), .irqOut(irqOut),
    .ramEnableOutN(ramEnableOutN), .powerfailFlagOutN(powerfailFlagOutN),
    .cmdValid(cmdValid), .cmdOut(cmdOut)
  );
  host_model i_host_model (
    .core_clk(core_clk), .csIn(csIn), .sclkIn(sclkIn), .sdiIn(sdiIn),
    .watchdogKickN(watchdogKickN)
  );
  always @(posedge core_clk) begin
    if (cmdValid === 1'b1) begin
      lastCmd <= cmdOut;
      cmdCount <= cmdCount + 1;
    end
  end
  task automatic check(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic stop_test();
    if (errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test
  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask : cyc
  task automatic waitOe(input logic v, input int lim);
    n = 0;
    #1;
    while (rstPinOe !== v) begin
      cyc(1);
      n++;
      if (n > lim) begin
        errors++;
        stop_test();
      end
    end
  endtask : waitOe
  task automatic powerUp();
    @(posedge core_clk);
    supplyInTol <= 1'b1;
    ramEnableInN <= 1'b0;
    cyc(10);
    check("oeHold", 8'(rstPinOe), 8'h01);
    check("ramHold", 8'(ramEnableOutN), 8'h01);
    waitOe(0, HOLD + 8);
    check("holdLen", 8'(n + 10 >= HOLD), 8'h01);
    cyc(4);
    check("ramRun", 8'(ramEnableOutN), 8'h00);
  endtask : powerUp
  task automatic cmdTest();
    logic [7:0] cmds [3] = '{8'h85, 8'h7f, 8'h80};
    int         c0;
    foreach (cmds[i]) begin
      @(posedge core_clk);
      i_host_model.kick();
      c0 = cmdCount;
      i_host_model.sendBits(cmds[i], 8);
      check("cmdCount", 8'(cmdCount - c0), 8'h01);
      check("cmdOut", lastCmd, cmds[i]);
    end
    c0 = cmdCount;
    i_host_model.sendBits(8'h85, 5);
    check("partial", 8'(cmdCount - c0), 8'h00);
  endtask : cmdTest
  task automatic sideTest();
    for (int v = 0; v < 2; v++) begin
      @(posedge core_clk);
      powerfailSenseIn <= v[0];
      cyc(4);
      check("pfo", 8'(powerfailFlagOutN), 8'(v));
    end
  endtask : sideTest
  task automatic irqTest();
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      alarmRequestFlag <= i[0];
      alarmIrqEnable <= i[1];
      cyc(2);
      check("irq", 8'(irqOut), 8'(i == 3));
      cyc(3);
      check("irqHold", 8'(irqOut), 8'(i == 3));
    end
  endtask : irqTest
  task automatic wdogTest();
    for (int i = 0; i < 6; i++) begin
      @(posedge core_clk);
      i_host_model.kick();
      cyc(WDOG / 2);
    end
    check("kickOk", 8'(rstPinOe), 8'h00);
    waitOe(1, WDOG);
    check("wdogLen", 8'(n + WDOG / 2 + 8 >= WDOG), 8'h01);
    waitOe(0, BTN + 4);
    check("wdogRst", 8'(n >= BTN), 8'h01);
  endtask : wdogTest
  task automatic btnTest();
    @(posedge core_clk);
    buttonN <= 1'b0;
    waitOe(1, DEB + 8);
    check("debounce", 8'(n >= DEB), 8'h01);
    @(posedge core_clk);
    buttonN <= 1'b1;
    waitOe(0, BTN + 4);
    check("btnLen", 8'(n + 1 >= BTN), 8'h01);
  endtask : btnTest
  task automatic dropTest();
    int c0;
    @(posedge core_clk);
    supplyInTol <= 1'b0;
    cyc(4);
    check("oeDrop", 8'(rstPinOe), 8'h01);
    check("rstOut", 8'(rstPinOut), 8'h00);
    c0 = cmdCount;
    i_host_model.sendBits(8'h85, 8);
    check("offCmd", 8'(cmdCount - c0), 8'h00);
    check("ramDrop", 8'(ramEnableOutN), 8'h01);
    irqTest();
    @(posedge core_clk);
    supplyInTol <= 1'b1;
    waitOe(0, HOLD + 8);
    check("reHold", 8'(n >= HOLD), 8'h01);
  endtask : dropTest
  initial begin
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    powerUp();
    cmdTest();
    sideTest();
    irqTest();
    wdogTest();
    btnTest();
    dropTest();
    stop_test();
  end
endmodule : cpu_supervisor_host_port_test
